/* rtl/tsod_pkg.sv */
// Constants, types and register map of the timer state output driver
//==================================================================
// Behaviour
// - An output switches on when the timer enters its turn-on state.
// - An output stays on, then switches off on entering its turn-off state.
// - Turn-on and turn-off each select one of five timer states.
// - Inverted turn-on fires on entering any state except the named one.
// - Inverted turn-off fires on entering any state except the named one.
// - On at X with off at not-X gives an output on only inside X.
// - Enable gates the output and leaves its other settings untouched.
// - Annunciator one lights while the first output is on.
// - After the turn-on event the output waits the programmed delay, then closes.
// - Delay counts whole seconds, at most 32400.
// - Zero delay closes the output at once.
// - The second output behaves the same, configured on its own.
// - Annunciator two lights while the second output is on.
// - Run time accumulates into a grand total; a zeroing command clears it.
// - Configuration is guarded by a four-character code; the default code opens it.
// - A new lock code takes effect only on return to display operation.
// - Factory restore needs the confirmation word, restores all, returns to display.
// - Factory restore leaves the grand total alone.
// - Reset terminal closure resets the timer after 2 ms (quick) or 1 s.
package tsod_pkg;

   //==================================================================
   // Timer states
   localparam logic [2:0] ST_RESET   = 3'h0;
   localparam logic [2:0] ST_RUN     = 3'h1;
   localparam logic [2:0] ST_PAUSE   = 3'h2;
   localparam logic [2:0] ST_RDELAY  = 3'h3;
   localparam logic [2:0] ST_DONE    = 3'h4;

   typedef struct packed {
      logic       inv;
      logic [2:0] st;
   } tsod_sel_t;

   typedef struct packed {
      logic        en;
      tsod_sel_t   off_sel;
      tsod_sel_t   on_sel;
      logic [14:0] delay;
   } tsod_cfg_t;

   localparam int          CFG_W       = 24;
   localparam logic [14:0] DELAY_MAX   = 15'h7E90;
   localparam tsod_cfg_t   CFG_DEFAULT = '{en: 1'b0, off_sel: '{inv: 1'b0, st: ST_DONE},
                                           on_sel: '{inv: 1'b0, st: ST_RUN}, delay: 15'h0000};

   //==================================================================
   // Register map, byte addresses
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_OUT1    = 8'h04;
   localparam logic [7:0] A_OUT2    = 8'h08;
   localparam logic [7:0] A_STATUS  = 8'h0C;
   localparam logic [7:0] A_GTOTAL  = 8'h10;
   localparam logic [7:0] A_NEWCODE = 8'h14;
   localparam logic [7:0] A_UNLOCK  = 8'h18;
   localparam logic [7:0] A_CMD     = 8'h1C;
   localparam logic [7:0] A_CONFIRM = 8'h20;

   localparam int CTRL_QUICK  = 0;
   localparam int CMD_ZERO_GT = 0;
   localparam int CMD_EXIT    = 1;
   localparam int CMD_RESTORE = 2;

   localparam logic [31:0] LOCK_DEFAULT   = 32'h3030_3030;
   localparam logic [31:0] CONFIRM_WORD   = 32'h3575_7245;

   //==================================================================
   // Timing
   localparam int CLK_MHZ        = 250;
   localparam int QUICK_RESET_MS = 2;
   localparam int SLOW_RESET_S   = 1;
   localparam int QUICK_CYCLES   = QUICK_RESET_MS * CLK_MHZ * 1000;
   localparam int SLOW_CYCLES    = SLOW_RESET_S * CLK_MHZ * 1000000;

endpackage

/* rtl/tsod_top.sv */
// Timer state output driver: two switch outputs, lock code, grand total, reset terminal timing
`timescale 1ns/1ns
module tsod_top
#(
   parameter int QUICK_RESET_CYCLES = tsod_pkg::QUICK_CYCLES,
   parameter int SLOW_RESET_CYCLES  = tsod_pkg::SLOW_CYCLES
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        state_entry,
   input  wire logic [2:0]  state_code,
   input  wire logic        sec_tick,
   input  wire logic        reset_terminal_closed,
   output logic             timer_reset_req,
   output logic             first_switch_output,
   output logic             second_switch_output,
   output logic             annunciator_one,
   output logic             annunciator_two
);
   import tsod_pkg::*;

   //==================================================================
   // Helpers
   function automatic logic sel_hit(input tsod_sel_t s, input logic [2:0] st);
      sel_hit = s.inv ? (st != s.st) : (st == s.st);
   endfunction

   function automatic tsod_cfg_t cfg_from_word(input logic [31:0] w);
      tsod_cfg_t c;
      c = tsod_cfg_t'(w[CFG_W-1:0]);
      if (c.delay > DELAY_MAX)
         c.delay = DELAY_MAX;
      cfg_from_word = c;
   endfunction

   //==================================================================
   // APB decode
   logic        wr_en;
   logic        rd_setup;
   logic        mapped;
   logic        cfg_open;
   tsod_cfg_t   cfg_r [2];
   logic        quick_r;
   logic [31:0] lock_active_r;
   logic [31:0] lock_pending_r;
   logic [31:0] confirm_r;
   logic        unlocked_r;
   logic [31:0] gtotal_r;
   logic [2:0]  cur_state_r;
   logic [1:0]  out_r;
   logic [1:0]  pend_r;
   logic [14:0] cnt_r [2];
   logic [27:0] rst_cnt_r;
   logic        rst_fired_r;
   logic        restore_ok;
   logic        exit_cmd;

   assign pready   = 1'b1;
   assign mapped   = (paddr == A_CTRL) || (paddr == A_OUT1) || (paddr == A_OUT2) ||
                     (paddr == A_STATUS) || (paddr == A_GTOTAL) || (paddr == A_NEWCODE) ||
                     (paddr == A_UNLOCK) || (paddr == A_CMD) || (paddr == A_CONFIRM);
   assign pslverr  = psel && penable && !mapped;
   assign wr_en    = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   // Default code leaves the menu open to anyone
   assign cfg_open = unlocked_r || (lock_active_r == LOCK_DEFAULT);
   assign exit_cmd = wr_en && (paddr == A_CMD) && pwdata[CMD_EXIT];
   assign restore_ok = wr_en && cfg_open && (paddr == A_CMD) && pwdata[CMD_RESTORE] &&
                       (confirm_r == CONFIRM_WORD);

   //==================================================================
   // Read data, latched in the setup phase so it is a flop output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         case (paddr)
            A_CTRL:   prdata <= {31'h0000_0000, quick_r};
            A_OUT1:   prdata <= {8'h00, cfg_r[0]};
            A_OUT2:   prdata <= {8'h00, cfg_r[1]};
            A_STATUS: prdata <= {24'h00_0000, cur_state_r, cfg_open, pend_r, out_r};
            A_GTOTAL: prdata <= gtotal_r;
            A_CONFIRM: prdata <= confirm_r;
            default:  prdata <= 32'h0000_0000;
         endcase
      end
   end

   //==================================================================
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_r[0] <= CFG_DEFAULT;
         cfg_r[1] <= CFG_DEFAULT;
         quick_r  <= 1'b0;
      end
      else if (restore_ok)
      begin
         cfg_r[0] <= CFG_DEFAULT;
         cfg_r[1] <= CFG_DEFAULT;
         quick_r  <= 1'b0;
      end
      else if (wr_en && cfg_open)
      begin
         case (paddr)
            A_CTRL:  quick_r  <= pwdata[CTRL_QUICK];
            A_OUT1:  cfg_r[0] <= cfg_from_word(pwdata);
            A_OUT2:  cfg_r[1] <= cfg_from_word(pwdata);
            default: ;
         endcase
      end
   end

   //==================================================================
   // Lock code and menu access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lock_active_r  <= LOCK_DEFAULT;
         lock_pending_r <= LOCK_DEFAULT;
         unlocked_r     <= 1'b0;
         confirm_r      <= 32'h0000_0000;
      end
      else if (restore_ok)
      begin
         lock_active_r  <= LOCK_DEFAULT;
         lock_pending_r <= LOCK_DEFAULT;
         unlocked_r     <= 1'b0;
         confirm_r      <= 32'h0000_0000;
      end
      else if (exit_cmd)
      begin
         // The new code only bites once the menu is left
         lock_active_r <= lock_pending_r;
         unlocked_r    <= 1'b0;
         confirm_r     <= 32'h0000_0000;
      end
      else if (wr_en)
      begin
         case (paddr)
            A_UNLOCK:  unlocked_r <= unlocked_r || (pwdata == lock_active_r);
            A_NEWCODE: if (cfg_open) lock_pending_r <= pwdata;
            A_CONFIRM: if (cfg_open) confirm_r <= pwdata;
            default: ;
         endcase
      end
   end

   //==================================================================
   // Grand total of run seconds, untouched by factory restore
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gtotal_r <= 32'h0000_0000;
      else if (wr_en && cfg_open && (paddr == A_CMD) && pwdata[CMD_ZERO_GT])
         gtotal_r <= 32'h0000_0000;
      else if (sec_tick && (cur_state_r == ST_RUN))
         gtotal_r <= gtotal_r + 32'h0000_0001;
   end

   //==================================================================
   // Present timer state, tracked from entry events
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cur_state_r <= ST_RESET;
      else if (state_entry)
         cur_state_r <= state_code;
   end

   //==================================================================
   // Switch outputs with turn-on delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_r  <= 2'h0;
         pend_r <= 2'h0;
         cnt_r[0] <= 15'h0000;
         cnt_r[1] <= 15'h0000;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (!cfg_r[i].en)
            begin
               out_r[i]  <= 1'b0;
               pend_r[i] <= 1'b0;
            end
            else if (state_entry && sel_hit(cfg_r[i].off_sel, state_code))
            begin
               // Off beats on if one entry hits both selections
               out_r[i]  <= 1'b0;
               pend_r[i] <= 1'b0;
            end
            else if (state_entry && sel_hit(cfg_r[i].on_sel, state_code) && !out_r[i] && !pend_r[i])
            begin
               if (cfg_r[i].delay == 15'h0000)
                  out_r[i] <= 1'b1;
               else
               begin
                  pend_r[i] <= 1'b1;
                  cnt_r[i]  <= cfg_r[i].delay;
               end
            end
            else if (pend_r[i] && sec_tick)
            begin
               if (cnt_r[i] == 15'h0001)
               begin
                  out_r[i]  <= 1'b1;
                  pend_r[i] <= 1'b0;
               end
               cnt_r[i] <= cnt_r[i] - 15'h0001;
            end
         end
      end
   end

   assign first_switch_output  = out_r[0];
   assign second_switch_output = out_r[1];
   assign annunciator_one      = out_r[0];
   assign annunciator_two      = out_r[1];

   //==================================================================
   // Reset terminal closure timer; the slow figure rejects contact bounce
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_cnt_r       <= 28'h000_0000;
         rst_fired_r     <= 1'b0;
         timer_reset_req <= 1'b0;
      end
      else if (!reset_terminal_closed)
      begin
         rst_cnt_r       <= 28'h000_0000;
         rst_fired_r     <= 1'b0;
         timer_reset_req <= 1'b0;
      end
      else
      begin
         timer_reset_req <= 1'b0;
         if (!rst_fired_r)
         begin
            if (rst_cnt_r == 28'((quick_r ? QUICK_RESET_CYCLES : SLOW_RESET_CYCLES) - 1))
            begin
               timer_reset_req <= 1'b1;
               rst_fired_r     <= 1'b1;
            end
            rst_cnt_r <= rst_cnt_r + 28'h000_0001;
         end
      end
   end

   //==================================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_zero_delay_on;
      state_entry && cfg_r[0].en && sel_hit(cfg_r[0].on_sel, state_code) &&
      !sel_hit(cfg_r[0].off_sel, state_code) && cfg_r[0].delay == 15'h0000 && !(wr_en && paddr == A_OUT1)
      |=> first_switch_output;
   endproperty
   a_zero_delay_on: assert property (p_zero_delay_on) else $error("zero delay output not on");

   property p_off_entry;
      state_entry && sel_hit(cfg_r[1].off_sel, state_code) |=> !second_switch_output && !pend_r[1];
   endproperty
   a_off_entry: assert property (p_off_entry) else $error("output not off after off entry");

   property p_disabled_off;
      !cfg_r[0].en |=> !first_switch_output;
   endproperty
   a_disabled_off: assert property (p_disabled_off) else $error("disabled output is on");

   property p_annunciators;
      annunciator_one == first_switch_output && annunciator_two == second_switch_output;
   endproperty
   a_annunciators: assert property (p_annunciators) else $error("annunciator mismatch");

   property p_hold_between;
      !state_entry && !pend_r[0] && $stable(cfg_r[0]) ##1 $stable(cfg_r[0]) |-> $stable(first_switch_output);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("output moved without entry");

   property p_delay_expiry;
      pend_r[0] && sec_tick && cnt_r[0] == 15'h0001 && cfg_r[0].en && !state_entry && $stable(cfg_r[0])
      |=> first_switch_output ##1 first_switch_output || state_entry || !cfg_r[0].en;
   endproperty
   a_delay_expiry: assert property (p_delay_expiry) else $error("delay expiry missed");

   property p_zero_gtotal;
      wr_en && cfg_open && paddr == A_CMD && pwdata[CMD_ZERO_GT] |=> gtotal_r == 32'h0000_0000;
   endproperty
   a_zero_gtotal: assert property (p_zero_gtotal) else $error("grand total not zeroed");

   property p_restore_keeps_total;
      restore_ok && !pwdata[CMD_ZERO_GT] && !(sec_tick && cur_state_r == ST_RUN) |=> $stable(gtotal_r);
   endproperty
   a_restore_keeps_total: assert property (p_restore_keeps_total) else $error("restore hit total");

   property p_code_deferred;
      wr_en && paddr == A_NEWCODE && !exit_cmd |=> $stable(lock_active_r);
   endproperty
   a_code_deferred: assert property (p_code_deferred) else $error("lock code applied early");

   property p_reset_pulse;
      timer_reset_req |-> $past(reset_terminal_closed) ##1 !timer_reset_req;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse) else $error("reset request not one pulse");

endmodule

/* bench/tsod_apparatus.sv */
// Model of the apparatus on the switch outputs, with the second contact wired to the reset terminals
`timescale 1ns/1ns
module tsod_apparatus
(
   input  wire logic second_switch_output,
   input  wire logic wired,
   input  wire logic manual_closed,
   output logic      reset_terminal_closed
);
   // A wired contact shorts the terminals as a push button would; unwired, a manual button drives them
   assign reset_terminal_closed = wired ? second_switch_output : manual_closed;
endmodule

/* bench/tsod_top_tb_top.sv */
// Self-checking testbench of the timer state output driver
`timescale 1ns/1ns
module tsod_top_tb_top;
   import tsod_pkg::*;
   localparam int QC = 20;
   localparam int SC = 50;
   logic        pclk, presetn, psel, penable, pwrite, state_entry, sec_tick, wired, manual;
   logic        pready, pslverr, rtc, trq, o1, o2, a1, a2, e;
   logic [7:0]  paddr;
   logic [2:0]  state_code;
   logic [31:0] pwdata, prdata, q, x, y, g;
   int          n_fail, checked, d, k;

   tsod_top #(.QUICK_RESET_CYCLES(QC), .SLOW_RESET_CYCLES(SC)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .state_entry(state_entry), .state_code(state_code),
      .sec_tick(sec_tick), .reset_terminal_closed(rtc), .timer_reset_req(trq), .first_switch_output(o1),
      .second_switch_output(o2), .annunciator_one(a1), .annunciator_two(a2));
   tsod_apparatus i_app (.second_switch_output(o2), .wired(wired), .manual_closed(manual),
      .reset_terminal_closed(rtc));

   always #2 pclk = ~pclk;

   //==================================================================
   // Tasks
   task close_out();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] dt);
      apb(1'b1, a, dt);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk32(q & m, exp);
   endtask
   // Entry and tick are one-cycle pulses; #1 lets the registered outputs land before a check
   task ev(input logic en, input logic tk, input logic [2:0] c);
      @(posedge pclk);
      state_entry <= en;
      sec_tick <= tk;
      state_code <= c;
      @(posedge pclk);
      state_entry <= 1'b0;
      sec_tick <= 1'b0;
      #1;
   endtask
   task wt(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   task cnt();
      k = 0;
      while (trq !== 1'b1 && k < 300)
      begin
         wt(1);
         k++;
      end
   endtask
   function automatic logic [31:0] cfg(logic en, logic fi, logic [2:0] fs, logic ni, logic [2:0] ns,
                                       logic [14:0] dl);
      return {8'h00, en, fi, fs, ni, ns, dl};
   endfunction

   //==================================================================
   // Sequence
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, state_entry, sec_tick, wired, manual} = '0;
      {paddr, state_code, pwdata, n_fail, checked} = '0;
      x = $urandom(32'h1713ebc5);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wt(1);
      chk1(o1 | o2 | trq, 1'b0);
      wr(A_UNLOCK, LOCK_DEFAULT);
      rdc(A_STATUS, 32'h10, 32'h10);
      apb(1'b0, 8'h24, 32'h0);
      chk1(e, 1'b1);
      chk32(q, 32'h0);
      chk1(pready, 1'b1);
      for (int s = 0; s < 5; s++)
      begin
         wr(A_OUT1, cfg(1'b1, 1'b1, 3'(s), 1'b0, 3'(s), 15'h0));
         ev(1'b1, 1'b0, 3'(s));
         chk1(o1, 1'b1);
         ev(1'b1, 1'b0, 3'((s + 1) % 5));
         chk1(o1, 1'b0);
         wr(A_OUT1, cfg(1'b1, 1'b0, 3'(s), 1'b1, 3'(s), 15'h0));
         ev(1'b1, 1'b0, 3'((s + 4) % 5));
         chk1(a1, 1'b1);
         ev(1'b1, 1'b0, 3'(s));
         chk1(o1, 1'b0);
      end
      y = cfg(1'b1, 1'b0, ST_DONE, 1'b0, ST_RUN, 15'h5);
      wr(A_OUT1, y & 32'hFFFF8000);
      ev(1'b1, 1'b0, ST_RUN);
      ev(1'b1, 1'b1, ST_PAUSE);
      chk1(o1, 1'b1);
      wr(A_OUT1, y & 32'h7F8005);
      wt(2);
      chk1(o1, 1'b0);
      rdc(A_OUT1, 32'hFFFFFFFF, y & 32'h7F8005);
      wr(A_OUT1, y);
      ev(1'b1, 1'b0, ST_RESET);
      chk1(o1, 1'b0);
      d = 1 + $urandom % 4;
      wr(A_OUT2, cfg(1'b1, 1'b0, ST_DONE, 1'b0, ST_RUN, 15'(d)));
      ev(1'b1, 1'b0, ST_RUN);
      repeat (d - 1) ev(1'b0, 1'b1, ST_RUN);
      wt(2);
      chk1(o2, 1'b0);
      ev(1'b0, 1'b1, ST_RUN);
      wt(2);
      chk1(o2 & a2 & ~o1, 1'b1);
      ev(1'b1, 1'b0, ST_DONE);
      ev(1'b1, 1'b0, ST_RUN);
      ev(1'b0, 1'b1, ST_RUN);
      ev(1'b1, 1'b0, ST_DONE);
      repeat (d + 1) ev(1'b0, 1'b1, ST_DONE);
      chk1(o2, 1'b0);
      wr(A_OUT2, cfg(1'b1, 1'b0, ST_DONE, 1'b0, ST_RUN, 15'h7FFF));
      rdc(A_OUT2, 32'h7FFF, 32'h7E90);
      ev(1'b1, 1'b0, ST_RUN);
      wr(A_CMD, 32'h1);
      d = 1 + $urandom % 6;
      repeat (d) ev(1'b0, 1'b1, ST_RUN);
      rdc(A_GTOTAL, 32'hFFFFFFFF, 32'(d));
      // A tick landing with the pause entry still closes a run second
      ev(1'b1, 1'b1, ST_PAUSE);
      ev(1'b0, 1'b1, ST_PAUSE);
      rdc(A_GTOTAL, 32'hFFFFFFFF, 32'(d + 1));
      // Clear output one and cancel the second output's pending delay, since a config write leaves it armed
      ev(1'b1, 1'b0, ST_DONE);
      wr(A_CTRL, 32'h1);
      wr(A_OUT2, cfg(1'b1, 1'b0, ST_RESET, 1'b0, ST_DONE, 15'h0));
      @(posedge pclk) wired <= 1'b1;
      ev(1'b1, 1'b0, ST_DONE);
      cnt();
      chk1(k >= QC - 1 && k <= QC + 3, 1'b1);
      ev(1'b1, 1'b0, ST_RESET);
      wr(A_CTRL, 32'h0);
      @(posedge pclk) wired <= 1'b0;
      @(posedge pclk) manual <= 1'b1;
      wt(30);
      @(posedge pclk) manual <= 1'b0;
      @(posedge pclk) manual <= 1'b1;
      cnt();
      chk1(k >= SC - 1 && k <= SC + 3, 1'b1);
      @(posedge pclk) manual <= 1'b0;
      wr(A_NEWCODE, x);
      rdc(A_STATUS, 32'h10, 32'h10);
      wr(A_CMD, 32'h2);
      wr(A_OUT1, 32'h0);
      wr(A_UNLOCK, LOCK_DEFAULT);
      rdc(A_STATUS, 32'h10, 32'h0);
      wr(A_UNLOCK, x);
      rdc(A_STATUS, 32'h10, 32'h10);
      rdc(A_OUT1, 32'hFFFFFFFF, y);
      g = $urandom & 32'h7FFFFFFF;
      wr(A_CONFIRM, g);
      rdc(A_CONFIRM, 32'hFFFFFFFF, g);
      wr(A_CMD, 32'h4);
      rdc(A_OUT1, 32'hFFFFFFFF, y);
      wr(A_CONFIRM, CONFIRM_WORD);
      wr(A_CMD, 32'h4);
      rdc(A_OUT1, 32'hFFFFFFFF, cfg(1'b0, 1'b0, ST_DONE, 1'b0, ST_RUN, 15'h0));
      rdc(A_STATUS, 32'h10, 32'h10);
      rdc(A_GTOTAL, 32'hFFFFFFFF, 32'(d + 1));
      wr(A_UNLOCK, LOCK_DEFAULT);
      rdc(A_STATUS, 32'h10, 32'h10);
      close_out();
   end

   initial
   begin
      #100000;
      n_fail++;
      close_out();
   end
endmodule
